// [pkg/icc_pkg.sv]
package icc_pkg;

  // Register map, word index on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BUF = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;

  // Control register field positions
  localparam int IDLE_BIT = 13;
  localparam int TSEL_BIT = 7;
  localparam int CPI_LSB = 5;
  localparam int OV_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int MODE_LSB = 0;

  // Capture mode encodings
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_BOTH = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h6;
  localparam logic [2:0] MODE_WAKE = 3'h7;

  // Prescaler terminal counts
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;

  // Interrupt status and mask bit positions
  localparam int EV_CAP = 0;
  localparam int EV_OVF = 1;
  localparam int EV_WAKE = 2;

  // Buffer depth
  localparam logic [2:0] FIFO_DEPTH = 3'h4;

  typedef struct packed {
    logic push;
    logic pop;
    logic flush;
    logic [15:0] data;
  } icc_fifo_in_t;

  typedef struct packed {
    logic [15:0] head;
    logic not_empty;
    logic full;
  } icc_fifo_out_t;

  typedef struct packed {
    logic [3:0][15:0] mem;
    logic [1:0] wr;
    logic [1:0] rd;
    logic [2:0] cnt;
  } icc_fifo_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [3:0] presc;
    logic [1:0] icnt;
    logic [2:0] mode;
    logic idle_stop;
    logic tsel;
    logic [1:0] cap_per_int;
    logic ov;
    logic [2:0] istat;
    logic [2:0] imask;
    logic [15:0] rdata;
    logic wake;
  } icc_state_t;

  localparam icc_fifo_state_t FIFO_RST = '0;
  localparam icc_state_t STATE_RST = '0;

endpackage

// [hdl/icc_fifo.sv]
`timescale 1ns/1ps
module icc_fifo
(
  input wire logic clk,
  input wire logic rstn,
  input icc_pkg::icc_fifo_in_t fin,
  output icc_pkg::icc_fifo_out_t fout
);

  icc_pkg::icc_fifo_state_t s_r;
  icc_pkg::icc_fifo_state_t s_nxt;
  logic do_push;
  logic do_pop;

  // Pointer and count update, oldest entry at the read pointer
  always_comb
  begin
    s_nxt = s_r;
    do_push = fin.push && (s_r.cnt != icc_pkg::FIFO_DEPTH);
    do_pop = fin.pop && (s_r.cnt != 3'h0);
    if (do_push)
    begin
      s_nxt.mem[s_r.wr] = fin.data;
      s_nxt.wr = 2'(s_r.wr + 2'h1);
    end
    if (do_pop)
      s_nxt.rd = 2'(s_r.rd + 2'h1);
    s_nxt.cnt = 3'(s_r.cnt + {2'h0, do_push} - {2'h0, do_pop});
    if (fin.flush)
    begin
      s_nxt.wr = 2'h0;
      s_nxt.rd = 2'h0;
      s_nxt.cnt = 3'h0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
      s_r <= icc_pkg::FIFO_RST;
    else
      s_r <= s_nxt;
  end

  // Head and status straight from flops
  assign fout.head = s_r.mem[s_r.rd];
  assign fout.not_empty = (s_r.cnt != 3'h0);
  assign fout.full = (s_r.cnt == icc_pkg::FIFO_DEPTH);

  // Stored value comes back out first
  fifo_order_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.cnt == 3'h0 && fin.push && !fin.flush) |=> (fout.head == $past(fin.data)))
    else $error("fifo head is not the oldest value");

endmodule // icc_fifo

// [hdl/icc_channel.sv]
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module icc_channel
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic capture_input_pin,
  input wire logic [15:0] second_timer_count,
  input wire logic [15:0] third_timer_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  output logic irq,
  output logic wake
);

  icc_pkg::icc_state_t s_r;
  icc_pkg::icc_state_t s_nxt;
  icc_pkg::icc_fifo_in_t fin;
  icc_pkg::icc_fifo_out_t fout;
  logic rise;
  logic fall;
  logic halted;
  logic low_power;
  logic cap_evt;
  logic int_evt;
  logic wake_evt;
  logic [2:0] ev_set;
  logic [15:0] ctrl_view;
  logic [15:0] tbase;

  // Edges from the second synchroniser stage only
  assign rise = s_r.sync2 && !s_r.prev;
  assign fall = !s_r.sync2 && s_r.prev;
  assign low_power = cpu_sleep || cpu_idle;
  assign halted = s_r.idle_stop && cpu_idle;

  // Selected time base
  assign tbase = s_r.tsel ? second_timer_count : third_timer_count;

  // Control register as software sees it, unused bits zero
  always_comb
  begin
    ctrl_view = 16'h0000;
    ctrl_view[icc_pkg::IDLE_BIT] = s_r.idle_stop;
    ctrl_view[icc_pkg::TSEL_BIT] = s_r.tsel;
    ctrl_view[icc_pkg::CPI_LSB +: 2] = s_r.cap_per_int;
    ctrl_view[icc_pkg::OV_BIT] = s_r.ov;
    ctrl_view[icc_pkg::BNE_BIT] = fout.not_empty;
    ctrl_view[icc_pkg::MODE_LSB +: 3] = s_r.mode;
  end

  // Channel behaviour, register port and next state
  always_comb
  begin
    s_nxt = s_r;
    cap_evt = 1'b0;
    int_evt = 1'b0;
    wake_evt = 1'b0;
    fin = '0;
    // Two-flop synchroniser, then edge history
    s_nxt.sync1 = capture_input_pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    // Capture event decode per mode
    unique case (s_r.mode)
      icc_pkg::MODE_OFF, icc_pkg::MODE_UNUSED:
        cap_evt = 1'b0;
      icc_pkg::MODE_BOTH:
        cap_evt = !halted && (rise || fall);
      icc_pkg::MODE_FALL:
        cap_evt = !halted && fall;
      icc_pkg::MODE_RISE:
        cap_evt = !halted && rise;
      icc_pkg::MODE_RISE4:
      begin
        if (!halted && rise)
        begin
          cap_evt = (s_r.presc == icc_pkg::PRE4_LAST);
          s_nxt.presc = cap_evt ? 4'h0 : 4'(s_r.presc + 4'h1);
        end
      end
      icc_pkg::MODE_RISE16:
      begin
        if (!halted && rise)
        begin
          cap_evt = (s_r.presc == icc_pkg::PRE16_LAST);
          s_nxt.presc = cap_evt ? 4'h0 : 4'(s_r.presc + 4'h1);
        end
      end
      icc_pkg::MODE_WAKE:
        wake_evt = low_power && rise;
    endcase
    // Store or flag overflow
    if (cap_evt)
    begin
      if (fout.full)
        s_nxt.ov = 1'b1;
      else
      begin
        fin.push = 1'b1;
        fin.data = tbase;
      end
    end
    // Captures-per-interrupt counter on stored values
    if (fin.push)
    begin
      if (s_r.mode == icc_pkg::MODE_BOTH)
        int_evt = 1'b1;
      else if (s_r.icnt == s_r.cap_per_int)
      begin
        int_evt = 1'b1;
        s_nxt.icnt = 2'h0;
      end
      else
        s_nxt.icnt = 2'(s_r.icnt + 2'h1);
    end
    // A capture while asleep or idle also wakes the core
    s_nxt.wake = wake_evt || (cap_evt && low_power);
    ev_set = 3'h0;
    ev_set[icc_pkg::EV_CAP] = int_evt;
    ev_set[icc_pkg::EV_OVF] = cap_evt && fout.full;
    ev_set[icc_pkg::EV_WAKE] = wake_evt;
    // Status bits: write one clears, a new event wins
    s_nxt.istat = s_r.istat | ev_set;
    if (wr_stb && addr == icc_pkg::ADDR_STAT)
      s_nxt.istat = (s_r.istat & ~wdata[2:0]) | ev_set;
    // Register writes
    if (wr_stb)
    begin
      unique case (addr)
        icc_pkg::ADDR_CTRL:
        begin
          s_nxt.idle_stop = wdata[icc_pkg::IDLE_BIT];
          s_nxt.tsel = wdata[icc_pkg::TSEL_BIT];
          s_nxt.cap_per_int = wdata[icc_pkg::CPI_LSB +: 2];
          s_nxt.mode = wdata[icc_pkg::MODE_LSB +: 3];
          // A mode change restarts prescaler and interrupt count
          if (wdata[icc_pkg::MODE_LSB +: 3] != s_r.mode)
          begin
            s_nxt.presc = 4'h0;
            s_nxt.icnt = 2'h0;
          end
        end
        icc_pkg::ADDR_MASK:
          s_nxt.imask = wdata[2:0];
        default:
          s_nxt.mode = s_nxt.mode;
      endcase
    end
    // Off mode empties the buffer and drops the overflow flag
    if (s_r.mode == icc_pkg::MODE_OFF)
    begin
      s_nxt.ov = 1'b0;
      s_nxt.presc = 4'h0;
      s_nxt.icnt = 2'h0;
      fin.flush = 1'b1;
    end
    // Register reads, data in the following cycle
    s_nxt.rdata = 16'h0000;
    if (rd_stb)
    begin
      unique case (addr)
        icc_pkg::ADDR_CTRL:
          s_nxt.rdata = ctrl_view;
        icc_pkg::ADDR_BUF:
        begin
          s_nxt.rdata = fout.not_empty ? fout.head : 16'h0000;
          fin.pop = fout.not_empty;
        end
        icc_pkg::ADDR_STAT:
          s_nxt.rdata = {13'h0000, s_r.istat};
        icc_pkg::ADDR_MASK:
          s_nxt.rdata = {13'h0000, s_r.imask};
        default:
          s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // State register, synchronous reset to all zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
      s_r <= icc_pkg::STATE_RST;
    else
      s_r <= s_nxt;
  end

  // Capture buffer
  icc_fifo u_fifo
  (
    .clk(clk),
    .rstn(rstn),
    .fin(fin),
    .fout(fout)
  );

  // Outputs
  assign rdata = s_r.rdata;
  assign irq = |(s_r.istat & s_r.imask);
  assign wake = s_r.wake;

  // Off mode never stores a value
  off_no_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_OFF) |-> !fin.push)
    else $error("capture stored while channel off");

  // Unused mode never stores a value
  unused_no_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_UNUSED) |-> !fin.push)
    else $error("capture stored in unused mode");

  // Wake mode never stores, and raises wake one cycle after a rise in low power
  wake_pin_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_WAKE && low_power && rise) |-> !fin.push ##1 wake)
    else $error("wake mode misbehaved on a rising edge");

  // Idle stop freezes capturing
  idle_halt_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.idle_stop && cpu_idle && s_r.mode != icc_pkg::MODE_WAKE) |-> !fin.push)
    else $error("capture stored while halted in idle");

  // Stored value is the selected timer
  timer_pick_a: assert property (@(posedge clk) disable iff (!rstn)
    fin.push |-> (fin.data == (s_r.tsel ? second_timer_count : third_timer_count)))
    else $error("wrong time base captured");

  // Rising edge mode stores on each rise unless full or halted
  rise_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_RISE && rise && !halted && !fout.full) |-> fin.push)
    else $error("rising edge not captured");

  // Falling edge mode stores only on falls
  fall_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_FALL && fin.push) |-> fall)
    else $error("capture without a falling edge");

  // Divide-by-four only fires on the fourth rise
  pre4_fire_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_RISE4 && cap_evt) |-> (s_r.presc == icc_pkg::PRE4_LAST))
    else $error("divide-by-four capture at wrong count");

  // Divide-by-sixteen only fires on the sixteenth rise
  pre16_fire_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_RISE16 && cap_evt) |-> (s_r.presc == icc_pkg::PRE16_LAST))
    else $error("divide-by-sixteen capture at wrong count");

  // Interrupt status set on the selected capture number
  cpi_count_a: assert property (@(posedge clk) disable iff (!rstn)
    (fin.push && s_r.mode != icc_pkg::MODE_BOTH && s_r.icnt == s_r.cap_per_int)
      |=> s_r.istat[icc_pkg::EV_CAP])
    else $error("capture interrupt missed");

  // Both-edge mode interrupts on every stored capture
  both_int_a: assert property (@(posedge clk) disable iff (!rstn)
    (fin.push && s_r.mode == icc_pkg::MODE_BOTH) |=> s_r.istat[icc_pkg::EV_CAP])
    else $error("both-edge capture without interrupt");

  // Capture into a full buffer sets overflow and stores nothing
  overflow_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (cap_evt && fout.full) |-> !fin.push ##1 s_r.ov)
    else $error("overflow not flagged");

  // Overflow survives writes while the channel is on
  ov_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.ov && s_r.mode != icc_pkg::MODE_OFF) |=> s_r.ov)
    else $error("overflow flag lost without off mode");

  // Control read shows zeros in unused bits and the buffer state
  ctrl_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (rd_stb && addr == icc_pkg::ADDR_CTRL)
      |=> (rdata[15:14] == 2'h0 && rdata[12:8] == 5'h00
           && rdata[3] == $past(fout.not_empty)))
    else $error("control read shows wrong bits");

  // Reset leaves the channel off and quiet
  reset_off_a: assert property (@(posedge clk)
    !rstn |=> (s_r.mode == icc_pkg::MODE_OFF && !s_r.ov && !irq && rdata == 16'h0000))
    else $error("channel not cleared by reset");

  // Software cannot raise the overflow flag
  ov_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (!s_r.ov && !(cap_evt && fout.full)) |=> !s_r.ov)
    else $error("overflow flag set without an overflow");

  // Off mode empties the buffer within one cycle
  off_flush_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_OFF) |=> !fout.not_empty)
    else $error("buffer not emptied while off");

  // Wake pulses in wake mode come only from a rise in low power
  wake_rise_only_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_WAKE && !(low_power && rise)) |=> !wake)
    else $error("wake pulse without a rising edge in low power");

  // Both-edge mode stores on either edge unless full or halted
  both_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_r.mode == icc_pkg::MODE_BOTH && (rise || fall) && !halted && !fout.full) |-> fin.push)
    else $error("edge not captured in both-edge mode");

  // Capture status clears on a written one unless a new event lands
  stat_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_stb && addr == icc_pkg::ADDR_STAT && wdata[icc_pkg::EV_CAP] && !int_evt)
      |=> !s_r.istat[icc_pkg::EV_CAP])
    else $error("capture status not cleared by a written one");

  // A new mode restarts the prescaler
  mode_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_stb && addr == icc_pkg::ADDR_CTRL && wdata[icc_pkg::MODE_LSB +: 3] != s_r.mode)
      |=> (s_r.presc == 4'h0))
    else $error("prescaler not restarted by a mode change");

  // A stored capture always shows as a non-empty buffer
  buf_filled_a: assert property (@(posedge clk) disable iff (!rstn)
    fin.push |=> fout.not_empty)
    else $error("buffer empty right after a store");

  // Buffer read returns the oldest entry
  buf_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (rd_stb && addr == icc_pkg::ADDR_BUF && fout.not_empty) |=> (rdata == $past(fout.head)))
    else $error("buffer read returned a wrong entry");

endmodule // icc_channel

// [testbench/icc_pin_model.sv]
`timescale 1ns/1ps
// Far-side driver of the capture pin, a plain digital source
module icc_pin_model
(
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;

  // One high then low pulse; short phases are stretched so the synchroniser sees them
  task automatic pulse(input int hi, input int lo);
    int h;
    int l;
    h = (hi < 2) ? 2 : hi;
    l = (lo < 2) ? 2 : lo;
    @(posedge clk);
    pin <= 1'b1;
    repeat (h) @(posedge clk);
    pin <= 1'b0;
    repeat (l - 1) @(posedge clk);
  endtask
endmodule // icc_pin_model

// [testbench/icc_channel_tb_top.sv]
`timescale 1ns/1ps
module icc_channel_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pin;
  logic [15:0] t2 = 16'h0000;
  logic [15:0] t3 = 16'h0000;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic wake;
  logic [15:0] rv;
  int err_total = 0;
  int compares = 0;
  int wake_cnt = 0;

  icc_pin_model i_pin (.clk(clk), .pin(pin));

  icc_channel i_dut (.clk(clk), .rstn(rstn), .capture_input_pin(pin),
    .second_timer_count(t2), .third_timer_count(t3), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .wake(wake));

  // Clock at 50 MHz
  initial
  begin
    forever #10 clk = ~clk;
  end

  // Counts one-cycle wake pulses
  always @(posedge clk)
  begin
    if (wake === 1'b1) wake_cnt++;
  end

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compares a seen value with the expected one
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register bus write and read
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // Captures caused by the p-th pulse in mode m
  function automatic int evts(input logic [2:0] m, input int p);
    case (m)
      icc_pkg::MODE_RISE, icc_pkg::MODE_FALL: return 1;
      icc_pkg::MODE_BOTH: return 2;
      icc_pkg::MODE_RISE4: return (p % 4 == 0) ? 1 : 0;
      icc_pkg::MODE_RISE16: return (p % 16 == 0) ? 1 : 0;
      default: return 0;
    endcase
  endfunction

  // Runs n pulses in mode m and checks status, interrupt and buffer contents
  task automatic run_mode(input logic [2:0] m, input int n, input logic [1:0] cpi,
    input logic tsel);
    logic [15:0] q[$];
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] st;
    logic ov;
    int stored;
    ov = 1'b0;
    stored = 0;
    wr(icc_pkg::ADDR_CTRL, 16'h0000);
    wr(icc_pkg::ADDR_STAT, 16'h0007);
    wr(icc_pkg::ADDR_MASK, 16'h0003);
    wr(icc_pkg::ADDR_CTRL, {8'h00, tsel, cpi, 2'b00, m});
    for (int p = 1; p <= n; p++)
    begin
      a = 16'($urandom);
      b = 16'($urandom);
      @(posedge clk);
      t2 <= a;
      t3 <= b;
      repeat (evts(m, p))
      begin
        if (q.size() < 4)
        begin
          q.push_back(tsel ? a : b);
          stored++;
        end
        else ov = 1'b1;
      end
      i_pin.pulse(3, 4);
    end
    repeat (2) @(posedge clk);
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("ctrl", rv, {8'h00, tsel, cpi, ov, q.size() != 0, m});
    st = {14'h0000, ov, stored > 0 && (m == icc_pkg::MODE_BOTH || stored >= cpi + 1)};
    rd(icc_pkg::ADDR_STAT, rv);
    chk("stat", rv, st);
    chk("irq", {15'h0000, irq}, {15'h0000, st != 16'h0000});
    while (q.size() > 0)
    begin
      rd(icc_pkg::ADDR_BUF, rv);
      chk("buf", rv, q.pop_front());
    end
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("empty", {15'h0000, rv[3]}, 16'h0000);
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'hBDA50B0B));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("ctrl rst", rv, 16'h0000);
    rd(icc_pkg::ADDR_STAT, rv);
    chk("stat rst", rv, 16'h0000);
    wr(icc_pkg::ADDR_CTRL, 16'hFFFF);
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("ctrl bits", rv, 16'h20E7);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, rv);
    chk("unmapped", rv, 16'h0000);
    // Each capture mode except wake, random interrupt rate for rise and fall, random time base for rise, fall and both-edge
    run_mode(icc_pkg::MODE_RISE, 3, 2'($urandom), 1'($urandom));
    run_mode(icc_pkg::MODE_FALL, 3, 2'($urandom), 1'($urandom));
    run_mode(icc_pkg::MODE_BOTH, 1, 2'h3, 1'($urandom));
    run_mode(icc_pkg::MODE_RISE4, 8, 2'h0, 1'b1);
    run_mode(icc_pkg::MODE_RISE16, 16, 2'h0, 1'b0);
    run_mode(icc_pkg::MODE_OFF, 5, 2'h0, 1'b1);
    run_mode(icc_pkg::MODE_UNUSED, 5, 2'h0, 1'b1);
    run_mode(icc_pkg::MODE_RISE, 6, 2'h1, 1'($urandom));
    wr(icc_pkg::ADDR_CTRL, 16'h0000);
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("ov clear", rv, 16'h0000);
    // Interrupt rate boundaries, one short of and exactly at the count
    for (int k = 0; k < 4; k++)
    begin
      if (k > 0) run_mode(icc_pkg::MODE_RISE, k, 2'(k), 1'($urandom));
      run_mode(icc_pkg::MODE_RISE, k + 1, 2'(k), 1'($urandom));
    end
    // Idle stop halts captures, clear lets them run
    wake_cnt = 0;
    wr(icc_pkg::ADDR_CTRL, 16'h2003);
    @(posedge clk);
    cpu_idle <= 1'b1;
    i_pin.pulse(3, 4);
    repeat (2) @(posedge clk);
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("idle stop", rv, 16'h2003);
    wr(icc_pkg::ADDR_CTRL, 16'h0003);
    i_pin.pulse(3, 4);
    repeat (2) @(posedge clk);
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("idle run", rv, 16'h000B);
    chk("idle wake", wake_cnt[15:0], 16'h0001);
    @(posedge clk);
    cpu_idle <= 1'b0;
    // Wake pin mode in sleep, then awake
    wr(icc_pkg::ADDR_CTRL, 16'h0000);
    wr(icc_pkg::ADDR_STAT, 16'h0007);
    wr(icc_pkg::ADDR_MASK, 16'h0004);
    wr(icc_pkg::ADDR_CTRL, 16'h00E7);
    wake_cnt = 0;
    @(posedge clk);
    cpu_sleep <= 1'b1;
    i_pin.pulse(3, 4);
    repeat (2) @(posedge clk);
    cpu_sleep <= 1'b0;
    chk("wake", wake_cnt[15:0], 16'h0001);
    rd(icc_pkg::ADDR_STAT, rv);
    chk("wake stat", rv, 16'h0004);
    chk("wake irq", {15'h0000, irq}, 16'h0001);
    rd(icc_pkg::ADDR_CTRL, rv);
    chk("wake nostore", rv, 16'h00E7);
    wr(icc_pkg::ADDR_STAT, 16'h0004);
    i_pin.pulse(3, 4);
    repeat (2) @(posedge clk);
    rd(icc_pkg::ADDR_STAT, rv);
    chk("awake", rv, 16'h0000);
    chk("irq off", {15'h0000, irq}, 16'h0000);
    wrap_up();
  end
endmodule // icc_channel_tb_top
